/* File: monitor_pkg.sv */
`default_nettype none
package monitor_pkg;
  // Parameter interface addresses
  localparam logic [15:0] ADDR_SOURCE_SEL   = 16'h0006;
  localparam logic [15:0] ADDR_POLARITY_SEL = 16'h0106;
  localparam logic [15:0] ADDR_PROP_A       = 16'h0108;
  localparam logic [15:0] ADDR_PROP_B       = 16'h010a;
  localparam logic [15:0] ADDR_OFFSET_A     = 16'h0428;
  localparam logic [15:0] ADDR_OFFSET_B     = 16'h042a;
  // Reset and range values
  localparam logic [6:0]  PROP_RESET        = 7'h64;
  localparam logic [6:0]  PROP_MAX          = 7'h64;
  localparam logic [7:0]  SOURCE_RESET      = 8'h00;
  localparam logic [1:0]  POLARITY_RESET    = 2'h0;
  localparam logic [15:0] POLARITY_MAX      = 16'h0003;
  localparam logic signed [15:0] OFFSET_B_RESET = 16'sh0000;
  localparam int          OFFSET_LIMIT_MV   = 800;
  // Source select digit positions and codes
  localparam int          SRC_A_LSB         = 0;
  localparam int          SRC_B_LSB         = 4;
  localparam logic [2:0]  SRC_RESERVED      = 3'h6;
  // Scaling: full scale quantity maps to 8 V at 100 percent
  localparam int          FULL_SCALE_MV     = 8000;
  localparam int          PCT_BASE          = 100;
  localparam int          QTY_MAX           = 32767;
  // Output quantisation, 13 mV per step
  localparam int          LSB_MV            = 13;
  localparam int          RECIP_SHIFT       = 16;
  localparam int          RECIP             = (1 << RECIP_SHIFT) / LSB_MV;
  localparam int          CODE_W            = 11;
  localparam int          CODE_LIMIT        = (FULL_SCALE_MV * RECIP) >> RECIP_SHIFT;
  // Divider geometry
  localparam int          NUM_W             = 36;
  localparam int          DEN_W             = 22;
  localparam int          MAG_CAP_MV        = 9000;

  // Result of one channel's scaling step
  typedef struct packed {
    logic        neg;
    logic [13:0] mag_mv;
  } scaled_t;
endpackage
`default_nettype wire

/* File: scale_divider.sv */
`default_nettype none
// Serial restoring divider; one quotient bit per clock
module scale_divider #(
  parameter int NW = 36,
  parameter int DW = 22
) (
  input  wire logic          clk,
  input  wire logic          rst,
  input  wire logic          start,
  input  wire logic [NW-1:0] num,
  input  wire logic [DW-1:0] den,
  output logic               done,
  output logic [NW-1:0]      quo
);
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } div_state_t;

  div_state_t        state_ff;     // Sequencer
  logic [NW-1:0]     shift_ff;     // Dividend shifting out, quotient in
  logic [DW:0]       rem_ff;       // Partial remainder
  logic [DW-1:0]     den_ff;       // Held divisor
  logic [7:0]        cnt_ff;       // Bits left
  logic [DW:0]       trial;        // Remainder with next bit
  logic [DW+1:0]     diff;         // Trial minus divisor

  // Zero divisor yields all ones, which later saturates
  always_comb begin
    trial = {rem_ff[DW-1:0], shift_ff[NW-1]};
    diff  = {1'b0, trial} - {2'b00, den_ff};
  end

  // Sequencer and datapath
  always_ff @(posedge clk) begin
    if (rst) begin
      state_ff <= ST_IDLE;
      shift_ff <= '0;
      rem_ff   <= '0;
      den_ff   <= '0;
      cnt_ff   <= 8'h00;
      done     <= 1'b0;
      quo      <= '0;
    end else begin
      done <= 1'b0;
      case (state_ff)
        ST_IDLE: begin
          if (start) begin
            shift_ff <= num;
            den_ff   <= den;
            rem_ff   <= '0;
            cnt_ff   <= 8'(NW);
            state_ff <= ST_RUN;
          end
        end
        ST_RUN: begin
          if (!diff[DW+1]) begin
            rem_ff   <= diff[DW:0];
            shift_ff <= {shift_ff[NW-2:0], 1'b1};
          end else begin
            rem_ff   <= trial;
            shift_ff <= {shift_ff[NW-2:0], 1'b0};
          end
          cnt_ff <= cnt_ff - 8'h01;
          if (cnt_ff == 8'h01) begin
            // Last bit lands in the same edge as done
            quo      <= {shift_ff[NW-2:0], ~diff[DW+1]};
            done     <= 1'b1;
            state_ff <= ST_IDLE;
          end
        end
        default: state_ff <= ST_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

/* File: analog_monitor_output_scaler.sv */
// Contract
// - Channel A scaled by its proportion percent
// - Channel B scaled by its proportion percent
// - Output saturates at plus or minus 8 V
// - Output quantised at about 13 mV steps
// - Signed offset per channel, -800..800 mV
// - Channel A offset survives restore defaults
// - Polarity setting accepts only 0 to 3
// - Polarity codes map to channel signs
// - Source digit picks quantity; 6 and 7 reserved
`default_nettype none
module analog_monitor_output_scaler #(
  parameter logic signed [15:0] FACTORY_OFFSET_A = 16'sh0000  // Calibration value
) (
  input  wire logic                               clk,
  input  wire logic                               rst,
  input  wire logic                               restore_defaults,
  input  wire logic [15:0]                        param_addr,
  input  wire logic                               param_wr,
  input  wire logic [15:0]                        param_wdata,
  input  wire logic                               param_rd,
  output logic [15:0]                             param_rdata,
  input  wire logic signed [15:0]                 motor_speed,
  input  wire logic signed [15:0]                 motor_torque,
  input  wire logic signed [15:0]                 pulse_cmd_freq,
  input  wire logic signed [15:0]                 speed_cmd,
  input  wire logic signed [15:0]                 torque_cmd,
  input  wire logic signed [15:0]                 bus_voltage,
  output logic signed [monitor_pkg::CODE_W-1:0]   monitor_channel_a,
  output logic signed [monitor_pkg::CODE_W-1:0]   monitor_channel_b
);
  import monitor_pkg::*;

  logic [6:0]         channel_a_proportion_ff;   // Percent, 0..100
  logic [6:0]         channel_b_proportion_ff;
  logic signed [15:0] channel_a_zero_offset_ff;  // mV
  logic signed [15:0] channel_b_zero_offset_ff;
  logic [7:0]         monitor_source_select_ff;  // Two digits
  logic [1:0]         monitor_polarity_select_ff;
  logic               start_ff;                  // Kicks both dividers
  logic [1:0]         done;                      // Divider finished
  logic [NUM_W-1:0]   quo [2];                   // Magnitudes in mV
  logic [NUM_W-1:0]   num [2];
  logic [DEN_W-1:0]   den [2];
  logic [1:0]         qneg;                      // Source sign at start
  logic [1:0]         neg_ff;                    // Sign held over division
  logic [1:0]         pol_neg;                   // Polarity per channel
  logic signed [CODE_W-1:0] code [2];
  logic signed [15:0] qsel [2];
  logic [2:0]         src  [2];
  logic [6:0]         prop [2];
  logic signed [15:0] offs [2];
  scaled_t            scaled [2];

  // Parameter writes; out of range values are refused, register keeps its value
  always_ff @(posedge clk) begin
    if (rst || restore_defaults) begin
      channel_a_proportion_ff    <= PROP_RESET;
      channel_b_proportion_ff    <= PROP_RESET;
      channel_b_zero_offset_ff   <= OFFSET_B_RESET;
      monitor_source_select_ff   <= SOURCE_RESET;
      monitor_polarity_select_ff <= POLARITY_RESET;
    end else if (param_wr) begin
      if (param_addr == ADDR_PROP_A) begin
        if (param_wdata <= 16'(PROP_MAX)) channel_a_proportion_ff <= param_wdata[6:0];
      end else if (param_addr == ADDR_PROP_B) begin
        if (param_wdata <= 16'(PROP_MAX)) channel_b_proportion_ff <= param_wdata[6:0];
      end else if (param_addr == ADDR_OFFSET_B) begin
        if ($signed(param_wdata) >= -16'(OFFSET_LIMIT_MV) &&
            $signed(param_wdata) <= 16'(OFFSET_LIMIT_MV))
          channel_b_zero_offset_ff <= param_wdata;
      end else if (param_addr == ADDR_SOURCE_SEL) begin
        if (param_wdata[15:8] == 8'h00 && !param_wdata[3] && !param_wdata[7])
          monitor_source_select_ff <= param_wdata[7:0];
      end else if (param_addr == ADDR_POLARITY_SEL) begin
        if (param_wdata <= POLARITY_MAX)
          monitor_polarity_select_ff <= param_wdata[1:0];
      end
    end
  end

  // Calibrated offset: only reset and direct writes touch it
  always_ff @(posedge clk) begin
    if (rst) begin
      channel_a_zero_offset_ff <= FACTORY_OFFSET_A;              // Calibration loads here
    end else if (param_wr && param_addr == ADDR_OFFSET_A &&
                 $signed(param_wdata) >= -16'(OFFSET_LIMIT_MV) &&
                 $signed(param_wdata) <= 16'(OFFSET_LIMIT_MV)) begin
      channel_a_zero_offset_ff <= param_wdata;
    end
  end
  // Restore pulse is absent above on purpose: calibration must survive it

  // Registered read port; unmapped addresses read zero
  always_ff @(posedge clk) begin
    if (rst) begin
      param_rdata <= 16'h0000;
    end else if (param_rd) begin
      if (param_addr == ADDR_PROP_A) param_rdata <= {9'h000, channel_a_proportion_ff};
      else if (param_addr == ADDR_PROP_B) param_rdata <= {9'h000, channel_b_proportion_ff};
      else if (param_addr == ADDR_OFFSET_A) param_rdata <= channel_a_zero_offset_ff;
      else if (param_addr == ADDR_OFFSET_B) param_rdata <= channel_b_zero_offset_ff;
      else if (param_addr == ADDR_SOURCE_SEL) param_rdata <= {8'h00, monitor_source_select_ff};
      else if (param_addr == ADDR_POLARITY_SEL) param_rdata <= {14'h0000, monitor_polarity_select_ff};
      else param_rdata <= 16'h0000;
    end
  end

  // Polarity decode: 0 ++, 1 +-, 2 and 3 --
  always_comb begin
    pol_neg[0] = monitor_polarity_select_ff[1];
    pol_neg[1] = monitor_polarity_select_ff != 2'h0;
    src[0]  = monitor_source_select_ff[SRC_A_LSB +: 3];
    src[1]  = monitor_source_select_ff[SRC_B_LSB +: 3];
    prop[0] = channel_a_proportion_ff;
    prop[1] = channel_b_proportion_ff;
    offs[0] = channel_a_zero_offset_ff;
    offs[1] = channel_b_zero_offset_ff;
  end

  // Retrigger both dividers as soon as the previous pass lands
  always_ff @(posedge clk) begin
    if (rst) start_ff <= 1'b1;
    else     start_ff <= done[0];
  end

  for (genvar c = 0; c < 2; c++) begin : g_chan
    // Quantity selection; reserved codes give zero
    always_comb begin
      logic [15:0] qmag;  // Size of the quantity; 16 bits also hold 32768
      qmag = 16'h0000;
      case (src[c])
        3'h0:    qsel[c] = motor_speed;
        3'h1:    qsel[c] = motor_torque;
        3'h2:    qsel[c] = pulse_cmd_freq;
        3'h3:    qsel[c] = speed_cmd;
        3'h4:    qsel[c] = torque_cmd;
        3'h5:    qsel[c] = bus_voltage;
        default: qsel[c] = 16'sh0000;
      endcase
      qneg[c] = qsel[c][15];
      // mV = 8000 * 100 * |q| / (QTY_MAX * percent); zero percent saturates a nonzero quantity
      qmag   = qneg[c] ? 16'(-qsel[c]) : qsel[c];
      num[c] = NUM_W'(qmag) * NUM_W'(FULL_SCALE_MV * PCT_BASE);
      // Zero quantity divides by one, so zero percent cannot make it full scale
      den[c] = (qsel[c] == 16'sh0000) ? DEN_W'(1) : DEN_W'(QTY_MAX) * DEN_W'(prop[c]);
    end

    // Sign follows the sample the divider took
    always_ff @(posedge clk) begin
      if (rst)           neg_ff[c] <= 1'b0;
      else if (start_ff) neg_ff[c] <= qneg[c] ^ pol_neg[c];
    end

    scale_divider #(.NW(NUM_W), .DW(DEN_W)) u_div (
      .clk   (clk),
      .rst   (rst),
      .start (start_ff),
      .num   (num[c]),
      .den   (den[c]),
      .done  (done[c]),
      .quo   (quo[c])
    );

    // Offset, clamp, then quantise to 13 mV steps
    always_comb begin
      logic signed [17:0] mv;
      logic signed [31:0] prod;
      logic signed [17:0] amv;  // Size of the clamped level
      mv = 18'sh0;
      prod = 32'sh0;
      amv = 18'sh0;
      scaled[c].neg    = neg_ff[c];
      scaled[c].mag_mv = (quo[c] > NUM_W'(MAG_CAP_MV)) ? 14'(MAG_CAP_MV) : quo[c][13:0];
      mv = scaled[c].neg ? -$signed({4'h0, scaled[c].mag_mv}) : $signed({4'h0, scaled[c].mag_mv});
      mv = mv + 18'(offs[c]);
      if (mv > 18'sd8000) mv = 18'sd8000;
      else if (mv < -18'sd8000) mv = -18'sd8000;
      // Quantise the size, then restore the sign; flooring a negative level
      // would land one step beyond -8 V
      amv = mv[17] ? -mv : mv;
      prod = 32'(amv) * 32'(RECIP);
      code[c] = mv[17] ? -CODE_W'(prod >>> RECIP_SHIFT)
                       : CODE_W'(prod >>> RECIP_SHIFT);
    end
  end

  // Outputs refresh once per finished pass
  always_ff @(posedge clk) begin
    if (rst) begin
      monitor_channel_a <= '0;
      monitor_channel_b <= '0;
    end else begin
      if (done[0]) monitor_channel_a <= code[0];
      if (done[1]) monitor_channel_b <= code[1];
    end
  end

  // Checks
  sequence restore_s;
    restore_defaults;
  endsequence

  clamp_a_a: assert property (@(posedge clk) disable iff (rst)
    monitor_channel_a <= CODE_W'(CODE_LIMIT) && monitor_channel_a >= -CODE_W'(CODE_LIMIT))
    else $error("channel a beyond 8 V");
  clamp_b_a: assert property (@(posedge clk) disable iff (rst)
    monitor_channel_b <= CODE_W'(CODE_LIMIT) && monitor_channel_b >= -CODE_W'(CODE_LIMIT))
    else $error("channel b beyond 8 V");
  prop_a_range_a: assert property (@(posedge clk) disable iff (rst)
    param_wr && param_addr == ADDR_PROP_A && param_wdata > 16'h0064 && !restore_defaults
    |=> $stable(channel_a_proportion_ff))
    else $error("proportion a took out of range value");
  prop_b_range_a: assert property (@(posedge clk) disable iff (rst)
    param_wr && param_addr == ADDR_PROP_B && !restore_defaults && param_wdata <= 16'h0064
    |=> channel_b_proportion_ff == $past(param_wdata[6:0]))
    else $error("proportion b not written");
  offset_range_a: assert property (@(posedge clk) disable iff (rst)
    channel_a_zero_offset_ff >= -16'sd800 && channel_a_zero_offset_ff <= 16'sd800 &&
    channel_b_zero_offset_ff >= -16'sd800 && channel_b_zero_offset_ff <= 16'sd800)
    else $error("offset out of range");
  offset_kept_a: assert property (@(posedge clk) disable iff (rst)
    restore_s and !param_wr |=> $stable(channel_a_zero_offset_ff))
    else $error("calibrated offset lost on restore");
  restore_prop_a: assert property (@(posedge clk) disable iff (rst)
    restore_s |=> channel_a_proportion_ff == 7'h64 && channel_b_proportion_ff == 7'h64)
    else $error("restore missed proportion");
  polarity_range_a: assert property (@(posedge clk) disable iff (rst)
    param_wr && param_addr == ADDR_POLARITY_SEL && param_wdata > 16'h0003 && !restore_defaults
    |=> $stable(monitor_polarity_select_ff))
    else $error("polarity took bad code");
  reserved_src_a: assert property (@(posedge clk) disable iff (rst)
    done[0] && src[0] >= SRC_RESERVED && channel_a_zero_offset_ff == 16'sh0000 &&
    $past(src[0], 37) >= SRC_RESERVED |=> monitor_channel_a == '0)
    else $error("reserved source drove output");
endmodule
`default_nettype wire

/* File: monitor_meter.sv */
`default_nettype none
// Bench-side instrument on the two monitor outputs; holds the peak level
module monitor_meter (
  input  wire logic                                    clk,
  input  wire logic                                    rst,
  input  wire logic signed [monitor_pkg::CODE_W-1:0]   code_a,
  input  wire logic signed [monitor_pkg::CODE_W-1:0]   code_b,
  output int                                           peak_mv
);
  import monitor_pkg::*;
  int mag_a;  // Channel a size in steps
  int mag_b;  // Channel b size in steps

  // A meter sees volts of either sign, so keep magnitudes only
  always_comb begin
    mag_a = (code_a < 0) ? -int'(code_a) : int'(code_a);
    mag_b = (code_b < 0) ? -int'(code_b) : int'(code_b);
  end

  // Peak hold in millivolts; cleared with the design so reset noise is not kept
  always_ff @(posedge clk) begin
    if (rst) begin
      peak_mv <= 0;
    end else if (mag_a * LSB_MV > peak_mv) begin
      peak_mv <= mag_a * LSB_MV;
    end else if (mag_b * LSB_MV > peak_mv) begin
      peak_mv <= mag_b * LSB_MV;
    end
  end
endmodule
`default_nettype wire

/* File: analog_monitor_output_scaler_tb_top.sv */
`default_nettype none
module analog_monitor_output_scaler_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import monitor_pkg::*;
  // One settings set and the codes it should give
  typedef struct packed {
    logic [2:0] src_a;
    logic [2:0] src_b;
    logic [1:0] pol;
    logic [15:0] prop_a;
    logic [15:0] prop_b;
    logic [15:0] off_a;
    logic [15:0] off_b;
    logic signed [CODE_W-1:0] exp_a;
    logic signed [CODE_W-1:0] exp_b;
  } row_t;
  // Every source digit and polarity code appears at least once
  localparam row_t ROWS [7] = '{
    '{3'h0, 3'h1, 2'h0, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 11'sh133, -11'sh09a},
    '{3'h2, 3'h3, 2'h1, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 11'sh267, -11'sh03e},
    '{3'h4, 3'h5, 2'h2, 16'h0064, 16'h0064, 16'h0000, 16'h0000, 11'sh267, 11'sh000},
    '{3'h0, 3'h6, 2'h3, 16'h0032, 16'h0064, 16'h0000, 16'h0000, -11'sh267, 11'sh000},
    '{3'h0, 3'h1, 2'h0, 16'h0019, 16'h0064, 16'hfce0, 16'h0320, 11'sh267, -11'sh05d},
    '{3'h2, 3'h5, 2'h0, 16'h0000, 16'h0000, 16'h0000, 16'hfce0, 11'sh267, -11'sh03e},
    '{3'h5, 3'h7, 2'h0, 16'h0064, 16'h0064, 16'h0320, 16'h0000, 11'sh03d, 11'sh000}};
  logic                      clk;          // 100 MHz
  logic                      rst;          // Sync reset
  logic                      restore_defaults;
  logic [15:0]               param_addr;
  logic                      param_wr;
  logic [15:0]               param_wdata;
  logic                      param_rd;
  logic [15:0]               param_rdata;
  logic signed [15:0]        qty [6];      // Monitored quantities
  logic signed [CODE_W-1:0]  mon_a;
  logic signed [CODE_W-1:0]  mon_b;
  int                        peak_mv;      // Meter peak reading
  int                        error_cnt;
  int                        n_checks;

  analog_monitor_output_scaler dut (
    .clk(clk), .rst(rst), .restore_defaults(restore_defaults),
    .param_addr(param_addr), .param_wr(param_wr), .param_wdata(param_wdata),
    .param_rd(param_rd), .param_rdata(param_rdata),
    .motor_speed(qty[0]), .motor_torque(qty[1]), .pulse_cmd_freq(qty[2]),
    .speed_cmd(qty[3]), .torque_cmd(qty[4]), .bus_voltage(qty[5]),
    .monitor_channel_a(mon_a), .monitor_channel_b(mon_b));

  monitor_meter meter (.clk(clk), .rst(rst), .code_a(mon_a), .code_b(mon_b),
    .peak_mv(peak_mv));

  // Free-running clock
  always #5 clk = ~clk;

  task automatic results();
    $display("checks %0d errors %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic check_reg(string name, logic [15:0] exp, logic [15:0] seen);
    n_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One step of slack: rounding direction of negative codes is left open
  task automatic check_code(string name, logic signed [CODE_W-1:0] exp,
                            logic signed [CODE_W-1:0] seen);
    n_checks++;
    if (seen !== exp && seen !== exp + 11'sh001 && seen !== exp - 11'sh001) begin
      error_cnt++;
      $display("wrong value %s expected %0d seen %0d", name, exp, seen);
    end
  endtask

  task automatic wr(logic [15:0] a, logic [15:0] d);
    @(posedge clk);
    param_addr <= a;
    param_wdata <= d;
    param_wr <= 1'b1;
    @(posedge clk);
    param_wr <= 1'b0;
  endtask

  // Read data lands on the same edge that takes the strobe
  task automatic rd_chk(string name, logic [15:0] a, logic [15:0] exp);
    @(posedge clk);
    param_addr <= a;
    param_rd <= 1'b1;
    @(posedge clk);
    param_rd <= 1'b0;
    #1;
    check_reg(name, exp, param_rdata);
  endtask

  // Two full 38-cycle passes so a pass starts after the last setting change
  task automatic settle();
    repeat (80) @(posedge clk);
    #1;
  endtask

  // Hang guard, well beyond the roughly 900 cycles the tests take
  initial begin
    repeat (6000) @(posedge clk);
    error_cnt++;
    results();
  end

  initial begin
    clk = 1'b0;
    rst = 1'b1;
    restore_defaults = 1'b0;
    param_addr = 16'h0000;
    param_wr = 1'b0;
    param_wdata = 16'h0000;
    param_rd = 1'b0;
    qty = '{16'sh4000, -16'sh2000, 16'sh7fff, 16'sh0ccd, -16'sh7fff, 16'sh0000};
    error_cnt = 0;
    n_checks = 0;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // Register defaults and an unmapped place
    rd_chk("prop_a", ADDR_PROP_A, 16'h0064);
    rd_chk("prop_b", ADDR_PROP_B, 16'h0064);
    rd_chk("off_a", ADDR_OFFSET_A, 16'h0000);
    rd_chk("off_b", ADDR_OFFSET_B, 16'h0000);
    rd_chk("source", ADDR_SOURCE_SEL, 16'h0000);
    rd_chk("polarity", ADDR_POLARITY_SEL, 16'h0000);
    rd_chk("unmapped", 16'h0200, 16'h0000);
    // Table of ordinary cases
    foreach (ROWS[i]) begin
      wr(ADDR_SOURCE_SEL, {9'h000, ROWS[i].src_b, 1'b0, ROWS[i].src_a});
      wr(ADDR_POLARITY_SEL, {14'h0000, ROWS[i].pol});
      wr(ADDR_PROP_A, ROWS[i].prop_a);
      wr(ADDR_PROP_B, ROWS[i].prop_b);
      wr(ADDR_OFFSET_A, ROWS[i].off_a);
      wr(ADDR_OFFSET_B, ROWS[i].off_b);
      settle();
      check_code("mon_a", ROWS[i].exp_a, mon_a);
      check_code("mon_b", ROWS[i].exp_b, mon_b);
    end
    // Out-of-range writes leave the old value
    wr(ADDR_PROP_A, 16'h0063);
    wr(ADDR_PROP_A, 16'h0065);
    rd_chk("prop_a", ADDR_PROP_A, 16'h0063);
    wr(ADDR_PROP_B, 16'h0065);
    rd_chk("prop_b", ADDR_PROP_B, 16'h0064);
    wr(ADDR_OFFSET_A, 16'h0321);
    rd_chk("off_a", ADDR_OFFSET_A, 16'h0320);
    wr(ADDR_OFFSET_B, 16'hfcdf);
    rd_chk("off_b", ADDR_OFFSET_B, 16'h0000);
    wr(ADDR_POLARITY_SEL, 16'h0004);
    rd_chk("polarity", ADDR_POLARITY_SEL, 16'h0000);
    wr(ADDR_POLARITY_SEL, 16'h0003);
    rd_chk("polarity", ADDR_POLARITY_SEL, 16'h0003);
    // Restore defaults spares the channel a offset only
    wr(ADDR_OFFSET_A, 16'h0123);
    wr(ADDR_PROP_B, 16'h001e);
    wr(ADDR_OFFSET_B, 16'h0100);
    @(posedge clk);
    restore_defaults <= 1'b1;
    @(posedge clk);
    restore_defaults <= 1'b0;
    rd_chk("off_a", ADDR_OFFSET_A, 16'h0123);
    rd_chk("prop_b", ADDR_PROP_B, 16'h0064);
    rd_chk("off_b", ADDR_OFFSET_B, 16'h0000);
    rd_chk("polarity", ADDR_POLARITY_SEL, 16'h0000);
    // Full negative scale pushed further by the offset must still clamp
    wr(ADDR_SOURCE_SEL, 16'h0004);
    wr(ADDR_OFFSET_A, 16'hfce0);
    settle();
    check_code("mon_a", -11'sh267, mon_a);
    check_code("mon_b", 11'sh133, mon_b);
    // Reserved source on channel a with no offset gives zero
    wr(ADDR_SOURCE_SEL, 16'h0006);
    wr(ADDR_OFFSET_A, 16'h0000);
    settle();
    check_code("mon_a", 11'sh000, mon_a);
    // Source word with upper bits set is refused
    wr(ADDR_SOURCE_SEL, 16'h0108);
    rd_chk("source", ADDR_SOURCE_SEL, 16'h0006);
    check_reg("peak_ok", 16'h0001, {15'h0000, peak_mv <= CODE_LIMIT * LSB_MV});
    results();
  end
endmodule
`default_nettype wire
